// [pfcss_adc_sched.sv]
// ADC slot scheduler for one PWM period.
// Assumes pwmCount restarts at zero each period; one request per slot.
`timescale 1ns/1ps
`default_nettype none
`include "pfcss_params.svh"
module pfcss_adc_sched
    import pfcss_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [CW-1:0] pwmCount,
    input wire logic [CW-1:0] onTime,
    input wire logic [CW-1:0] sampleTriggerDelay,
    input wire logic currentSlot,
    output logic adcTrigger,
    output pfcss_adc_ch_t adcChannel,
    output logic adcSampleHold
);
    localparam logic [7:0] SH = 8'(`PFCSS_SH_CYCLES);
    localparam logic [7:0] SLOT = 8'(`PFCSS_SLOT_CYCLES);

    pfcss_adc_ch_t ch_reg;
    logic [7:0] slot_reg;
    logic trig_reg;
    wire [CW-1:0] ilAt = (onTime >> 1) + sampleTriggerDelay;
    wire ilStart = currentSlot && (pwmCount == ilAt) && (onTime != '0);
    wire offStart = (pwmCount == onTime);
    wire slotEnd = (ch_reg != PFCSS_ADC_IDLE) && (slot_reg == SLOT - 8'h01);

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ch_reg <= PFCSS_ADC_IDLE;
            slot_reg <= 8'h00;
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= 1'b0;
            if (ilStart) begin
                ch_reg <= PFCSS_ADC_IL;
                slot_reg <= 8'h00;
                trig_reg <= 1'b1;
            end else if (offStart) begin
                ch_reg <= PFCSS_ADC_VAC1;
                slot_reg <= 8'h00;
                trig_reg <= 1'b1;
            end else if (slotEnd) begin
                slot_reg <= 8'h00;
                unique case (ch_reg)
                    PFCSS_ADC_VAC1: begin
                        ch_reg <= PFCSS_ADC_VAC2;
                        trig_reg <= 1'b1;
                    end
                    PFCSS_ADC_VAC2: begin
                        ch_reg <= PFCSS_ADC_VOUT;
                        trig_reg <= 1'b1;
                    end
                    default: ch_reg <= PFCSS_ADC_IDLE;
                endcase
            end else if (ch_reg != PFCSS_ADC_IDLE) begin
                slot_reg <= slot_reg + 8'h01;
            end
        end
    end

    assign adcTrigger = trig_reg;
    assign adcChannel = ch_reg;
    assign adcSampleHold = (ch_reg != PFCSS_ADC_IDLE) && (slot_reg < SH);
endmodule
`default_nettype wire

// [pfcss_params.svh]
// Constants for the converter sequencer and scheduler.
// Assumes a 25 MHz system clock; included by the ADC scheduler, rate generator and top modules.
`ifndef PFCSS_PARAMS_SVH
`define PFCSS_PARAMS_SVH

`define PFCSS_CLK_HZ 25000000
`define PFCSS_SEQ_HZ 1000
`define PFCSS_SEQ_CYCLES (`PFCSS_CLK_HZ / `PFCSS_SEQ_HZ)
`define PFCSS_T_SH_NS 333
`define PFCSS_T_CONV_NS 767
`define PFCSS_CLK_NS 40
`define PFCSS_SH_CYCLES ((`PFCSS_T_SH_NS + `PFCSS_CLK_NS - 1) / `PFCSS_CLK_NS)
`define PFCSS_CONV_CYCLES ((`PFCSS_T_CONV_NS + `PFCSS_CLK_NS - 1) / `PFCSS_CLK_NS)
`define PFCSS_SLOT_CYCLES (`PFCSS_SH_CYCLES + `PFCSS_CONV_CYCLES)
`define PFCSS_PWM_HZ_MIN 20000
`define PFCSS_PWM_HZ_MAX 100000
`define PFCSS_PWM_PERIOD_DEF 16'd500
`define PFCSS_PRIMARY_DIV_DEF 8'd10
`define PFCSS_MODE_CLOSED 2'h3
`define PFCSS_MODE_EXT_DUTY 2'h0
`define PFCSS_MODE_EXT_CUR 2'h1
`define PFCSS_MODE_EXT_MULT 2'h2

`endif

// [pfcss_pkg.sv]
// Types for the converter sequencer and scheduler.
// Codes of the sequencer state are visible at the top-level port.
package pfcss_pkg;
    typedef enum logic [2:0] {
        idle_config_state = 3'h0,
        offset_calibration_state = 3'h1,
        ext_duty_run_state = 3'h2,
        ext_current_run_state = 3'h3,
        ext_multiplier_run_state = 3'h4,
        fault_lock_state = 3'h5,
        closed_loop_run_state = 3'h6,
        low_power_state = 3'h7
    } pfcss_state_t;

    typedef enum logic [2:0] {
        PFCSS_ADC_IDLE = 3'h0,
        PFCSS_ADC_IL = 3'h1,
        PFCSS_ADC_VAC1 = 3'h2,
        PFCSS_ADC_VAC2 = 3'h3,
        PFCSS_ADC_VOUT = 3'h4
    } pfcss_adc_ch_t;
endpackage

// [pfcss_power_stage.sv]
// Power-stage model: current sense source and ADC trigger monitor.
// Assumes one clock domain shared with the sequencer block.
`timescale 1ns/1ps
`default_nettype none
module pfcss_power_stage
    import pfcss_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clearCounts,
    input wire logic gateOut,
    input wire logic adcTrigger,
    input wire pfcss_pkg::pfcss_adc_ch_t adcChannel,
    input wire logic [11:0] level,
    output logic [11:0] currentSample,
    output logic currentSampleValid,
    output logic [15:0] ilCount,
    output logic [15:0] vCount,
    output logic [15:0] badPhase,
    output logic [15:0] lastGap
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] gapReg;

    // Released sense line shows the inverse, never a stale value
    assign currentSample = currentSampleValid ? level : ~level;

    always_ff @(posedge clock) begin
        currentSampleValid <= nrst;
        if (!nrst || clearCounts) begin
            ilCount <= 16'h0000;
            vCount <= 16'h0000;
            badPhase <= 16'h0000;
            lastGap <= 16'h0000;
            gapReg <= 16'h0000;
        end else begin
            gapReg <= gapReg + 16'h0001;
            if (adcTrigger) begin
                gapReg <= 16'h0001;
                if (adcChannel == PFCSS_ADC_IL) begin
                    ilCount <= ilCount + 16'h0001;
                    badPhase <= badPhase + {15'h0000, !gateOut};
                end else if (adcChannel != PFCSS_ADC_IDLE) begin
                    vCount <= vCount + 16'h0001;
                    badPhase <= badPhase + {15'h0000, gateOut};
                    if (adcChannel != PFCSS_ADC_VAC1) lastGap <= gapReg;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [pfcss_rate_gen.sv]
// Rate generator: PWM period counter, base and primary enables.
// Assumes period and divider inputs are held stable while running.
`timescale 1ns/1ps
`default_nettype none
`include "pfcss_params.svh"
module pfcss_rate_gen #(
    parameter int CW = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [CW-1:0] pwmPeriod,
    input wire logic baseHalfRate,
    input wire logic [7:0] primaryDiv,
    output logic [CW-1:0] pwmCount,
    output logic pwmStart,
    output logic baseTick,
    output logic primaryTick
);
    if (CW < 8) begin : g_bad_width
        $error("pfcss_rate_gen: counter too narrow");
    end

    logic [CW-1:0] cnt_reg;
    logic odd_reg;
    logic [7:0] prim_reg;
    wire periodEnd = (cnt_reg >= pwmPeriod - CW'(1));
    wire baseNow = periodEnd && (!baseHalfRate || odd_reg);
    wire primEnd = (prim_reg >= primaryDiv - 8'h01) || (primaryDiv == 8'h00);

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_reg <= '0;
            odd_reg <= 1'b0;
            prim_reg <= 8'h00;
        end else begin
            cnt_reg <= periodEnd ? '0 : cnt_reg + CW'(1);
            if (periodEnd) odd_reg <= ~odd_reg;
            if (baseNow) prim_reg <= primEnd ? 8'h00 : prim_reg + 8'h01;
        end
    end

    assign pwmCount = cnt_reg;
    // Base runs every PWM period or every second one
    assign pwmStart = periodEnd;
    assign baseTick = baseNow;
    assign primaryTick = baseNow && primEnd;
endmodule
`default_nettype wire

// [pfcss_top.sv]
// Converter sequencer state machine and multi-rate scheduler.
// Assumes converter-side inputs are asynchronous pins; config is static.
`timescale 1ns/1ps
`default_nettype none
`include "pfcss_params.svh"
module pfcss_top
    import pfcss_pkg::*;
#(
    parameter int CW = 16,
    parameter int SEQ_CYCLES = `PFCSS_SEQ_CYCLES,
    parameter int CAL_EXP_MAX = 15
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic paramValid,
    input wire logic [1:0] loop_mode_select,
    input wire logic [3:0] calibration_length_exponent,
    input wire logic [11:0] currentSample,
    input wire logic currentSampleValid,
    input wire logic [11:0] offsetMin,
    input wire logic [11:0] offsetMax,
    input wire logic enableCmd,
    input wire logic startCmd,
    input wire logic faultPin,
    input wire logic ocpPin,
    input wire logic [15:0] standbyDelay,
    input wire logic [CW-1:0] pwmPeriod,
    input wire logic base_rate_setting,
    input wire logic [7:0] primary_rate_setting,
    input wire logic [CW-1:0] dutyIn,
    input wire logic dutyLoad,
    input wire logic [CW-1:0] sample_trigger_delay,
    output pfcss_state_t sequencer_state_code,
    output logic switching_enable_status,
    output logic [11:0] currentOffset,
    output logic gateOut,
    output logic lowPowerMode,
    output logic baseTick,
    output logic primaryTick,
    output logic sequencerTick,
    output logic adcTrigger,
    output pfcss_adc_ch_t adcChannel,
    output logic adcSampleHold,
    output logic converterPriority
);
    if (SEQ_CYCLES < 2) begin : g_bad_seq
        $error("pfcss_top: SEQ_CYCLES too small");
    end
    if (CAL_EXP_MAX > 15) begin : g_bad_cal
        $error("pfcss_top: CAL_EXP_MAX too large");
    end

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stages feed only second stages
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
        end else begin
            syncA_reg <= {faultPin, ocpPin, startCmd};
            syncB_reg <= syncA_reg;
        end
    end
    wire faultS = syncB_reg[2];
    wire ocpS = syncB_reg[1];
    wire startS = syncB_reg[0];

    ////////////////////////////////////////////////////////////////
    // Fixed sequencer tick, no configuration input reaches it
    logic [31:0] seqCnt_reg;
    wire seqTick = (seqCnt_reg == 32'(SEQ_CYCLES - 1));
    always_ff @(posedge clock) begin
        if (!nrst) seqCnt_reg <= 32'h0;
        else seqCnt_reg <= seqTick ? 32'h0 : seqCnt_reg + 32'h1;
    end

    ////////////////////////////////////////////////////////////////
    // Rates and ADC placement
    logic [CW-1:0] pwmCount;
    logic pwmStart;
    logic baseOdd_reg;
    pfcss_rate_gen #(.CW(CW)) uRate (
        .clock(clock),
        .nrst(nrst),
        .pwmPeriod(pwmPeriod),
        .baseHalfRate(base_rate_setting),
        .primaryDiv(primary_rate_setting),
        .pwmCount(pwmCount),
        .pwmStart(pwmStart),
        .baseTick(baseTick),
        .primaryTick(primaryTick)
    );

    // In half mode only the period that ends on a base tick samples current
    always_ff @(posedge clock) begin
        if (!nrst) baseOdd_reg <= 1'b0;
        else if (pwmStart) baseOdd_reg <= ~baseOdd_reg;
    end
    wire currentSlot = !base_rate_setting || baseOdd_reg;

    logic [CW-1:0] duty_reg;
    pfcss_adc_sched #(.CW(CW)) uAdc (
        .clock(clock),
        .nrst(nrst),
        .pwmCount(pwmCount),
        .onTime(duty_reg),
        .sampleTriggerDelay(sample_trigger_delay),
        .currentSlot(currentSlot),
        .adcTrigger(adcTrigger),
        .adcChannel(adcChannel),
        .adcSampleHold(adcSampleHold)
    );

    ////////////////////////////////////////////////////////////////
    // Duty shadow, applied only at period start
    logic [CW-1:0] dutyShadow_reg;
    logic pendingDuty_reg;
    wire dutyApply = pwmStart && (dutyLoad || pendingDuty_reg);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dutyShadow_reg <= '0;
            pendingDuty_reg <= 1'b0;
            duty_reg <= '0;
        end else begin
            if (dutyLoad) begin
                dutyShadow_reg <= dutyIn;
                pendingDuty_reg <= 1'b1;
            end else if (pwmStart) begin
                pendingDuty_reg <= 1'b0;
            end
            if (dutyApply) duty_reg <= dutyLoad ? dutyIn : dutyShadow_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Offset calibration accumulator
    pfcss_state_t state_reg;
    pfcss_state_t state_next;
    logic [31:0] calAcc_reg;
    logic [16:0] calCnt_reg;
    logic calDone_reg;
    wire inCal = (state_reg == offset_calibration_state);
    wire [16:0] calTarget = 17'h1 << calibration_length_exponent;
    wire [31:0] calMean = calAcc_reg >> calibration_length_exponent;
    always_ff @(posedge clock) begin
        if (!nrst || !inCal) begin
            calAcc_reg <= 32'h0;
            calCnt_reg <= 17'h0;
            calDone_reg <= 1'b0;
        end else if (pwmStart && !calDone_reg) begin
            if (currentSampleValid) calAcc_reg <= calAcc_reg + {20'h0, currentSample};
            calCnt_reg <= calCnt_reg + 17'h1;
            if (calCnt_reg + 17'h1 >= calTarget) calDone_reg <= 1'b1;
        end
    end
    wire [11:0] meanOffset = calMean[11:0];
    wire offsetOk = (meanOffset >= offsetMin) && (meanOffset <= offsetMax);

    always_ff @(posedge clock) begin
        if (!nrst) currentOffset <= 12'h000;
        else if (inCal && calDone_reg) currentOffset <= meanOffset;
    end

    ////////////////////////////////////////////////////////////////
    // Standby delay, counted in sequencer ticks
    logic [15:0] sbyCnt_reg;
    wire sbyExpired = (sbyCnt_reg >= standbyDelay);
    always_ff @(posedge clock) begin
        if (!nrst || state_reg != closed_loop_run_state || enableCmd) sbyCnt_reg <= 16'h0;
        else if (seqTick && !sbyExpired) sbyCnt_reg <= sbyCnt_reg + 16'h1;
    end

    ////////////////////////////////////////////////////////////////
    // Run state chosen by loop mode; each of the four codes selects a run state
    pfcss_state_t runState;
    always_comb begin
        unique case (loop_mode_select)
            `PFCSS_MODE_EXT_DUTY: runState = ext_duty_run_state;
            `PFCSS_MODE_EXT_CUR: runState = ext_current_run_state;
            `PFCSS_MODE_EXT_MULT: runState = ext_multiplier_run_state;
            `PFCSS_MODE_CLOSED: runState = closed_loop_run_state;
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            idle_config_state:
                if (paramValid) state_next = offset_calibration_state;
            offset_calibration_state:
                if (calDone_reg) state_next = offsetOk ? runState : fault_lock_state;
            fault_lock_state:
                state_next = fault_lock_state;
            ext_duty_run_state, ext_current_run_state, ext_multiplier_run_state:
                state_next = state_reg;
            closed_loop_run_state:
                if (!enableCmd && sbyExpired) state_next = low_power_state;
            low_power_state:
                if (startS || faultS) state_next = idle_config_state;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) state_reg <= idle_config_state;
        else if (seqTick) state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////
    // Gate: on-time from duty; faults and command suppress only
    wire inRun = (state_reg == ext_duty_run_state) || (state_reg == ext_current_run_state)
        || (state_reg == ext_multiplier_run_state) || (state_reg == closed_loop_run_state);
    wire swEnable = inRun && enableCmd && !faultS;
    logic ocpLatch_reg;
    always_ff @(posedge clock) begin
        if (!nrst) ocpLatch_reg <= 1'b0;
        else if (pwmStart) ocpLatch_reg <= ocpS;
        else if (ocpS) ocpLatch_reg <= 1'b1;
    end
    wire ocpBlock = ocpLatch_reg || ocpS;
    wire onWindow = (pwmCount < duty_reg);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            gateOut <= 1'b0;
            switching_enable_status <= 1'b0;
            lowPowerMode <= 1'b0;
        end else begin
            gateOut <= swEnable && !ocpBlock && onWindow;
            switching_enable_status <= swEnable;
            lowPowerMode <= (state_reg == low_power_state);
        end
    end

    assign sequencer_state_code = state_reg;
    assign sequencerTick = seqTick;
    // Converter work always outranks motor work; no motor PWM input exists
    assign converterPriority = 1'b1;

    ////////////////////////////////////////////////////////////////
    // Sequencing checks
    a_idle_after_reset: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> state_reg == idle_config_state)
        else $error("not idle after reset");

    a_fault_locked: assert property (@(posedge clock) disable iff (!nrst)
        state_reg == fault_lock_state |=> state_reg == fault_lock_state)
        else $error("fault lock left");

    a_state_tick_only: assert property (@(posedge clock) disable iff (!nrst)
        !seqTick |=> $stable(state_reg))
        else $error("state moved off tick");

    a_run_kept: assert property (@(posedge clock) disable iff (!nrst)
        (inRun && state_reg != closed_loop_run_state) |=> state_reg == $past(state_reg))
        else $error("run state left");

    a_standby_entry: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == low_power_state && $past(state_reg) != low_power_state)
        |-> $past(state_reg) == closed_loop_run_state)
        else $error("bad standby entry");

    a_standby_exit: assert property (@(posedge clock) disable iff (!nrst)
        ($past(state_reg) == low_power_state && state_reg != low_power_state)
        |-> state_reg == idle_config_state)
        else $error("standby not left via idle");

    a_cal_fault: assert property (@(posedge clock) disable iff (!nrst)
        (seqTick && inCal && calDone_reg && !offsetOk) |=> state_reg == fault_lock_state)
        else $error("bad offset not locked");

    a_cal_length: assert property (@(posedge clock) disable iff (!nrst)
        (inCal && calDone_reg) |-> calCnt_reg == calTarget)
        else $error("calibration count off");

    // Gate and status checks
    a_gate_fault: assert property (@(posedge clock) disable iff (!nrst)
        faultS |=> !gateOut)
        else $error("gate on during fault");

    a_ocp_gate_off: assert property (@(posedge clock) disable iff (!nrst)
        ocpBlock |=> !gateOut)
        else $error("gate on during overcurrent");

    a_cmd_gate_off: assert property (@(posedge clock) disable iff (!nrst)
        !enableCmd |=> !gateOut)
        else $error("gate on while disabled");

    a_lock_no_gate: assert property (@(posedge clock) disable iff (!nrst)
        state_reg == fault_lock_state |=> !gateOut && !switching_enable_status)
        else $error("gate on in fault lock");

    a_status_enable: assert property (@(posedge clock) disable iff (!nrst)
        (inRun && enableCmd && !faultS) |=> switching_enable_status)
        else $error("enable status missing");

    a_status_fault: assert property (@(posedge clock) disable iff (!nrst)
        faultS |=> !switching_enable_status)
        else $error("enable status during fault");

    a_low_power_flag: assert property (@(posedge clock) disable iff (!nrst)
        state_reg == low_power_state |=> lowPowerMode)
        else $error("low power flag missing");

    // Rate checks
    a_duty_sync: assert property (@(posedge clock) disable iff (!nrst)
        !pwmStart |=> $stable(duty_reg))
        else $error("duty changed mid period");

    a_base_full_rate: assert property (@(posedge clock) disable iff (!nrst)
        (!base_rate_setting && pwmStart) |-> baseTick)
        else $error("base tick missing");

    a_half_rate_align: assert property (@(posedge clock) disable iff (!nrst)
        (base_rate_setting && pwmStart) |-> baseTick == currentSlot)
        else $error("current slot off base tick");

    a_primary_in_base: assert property (@(posedge clock) disable iff (!nrst)
        primaryTick |-> baseTick)
        else $error("primary tick off base tick");
endmodule
`default_nettype wire

// [pfcss_top_tb.sv]
// Self-checking bench for the converter sequencer and scheduler.
// Assumes the power-stage model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED at %0t: got %0h want %0h", $time, a, e); end end
module pfcss_top_tb;
    import pfcss_pkg::*;
    // Short tick keeps the calibration runs within a few thousand cycles
    localparam int SEQ = 20;
    localparam int PER = 200;
    localparam int DUTY = 80;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic paramValid = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] calExp = 4'h2;
    logic [11:0] offsetMax = 12'h0C8;
    logic [11:0] level = 12'h096;
    logic enableCmd = 1'b0, startCmd = 1'b0, faultPin = 1'b0, ocpPin = 1'b0;
    logic baseHalf = 1'b0, dutyLoad = 1'b0, clearCounts = 1'b0;
    logic [15:0] dutyIn = 16'h0050;
    pfcss_state_t sequencer_state_code, prevState;
    pfcss_adc_ch_t adcChannel;
    logic switching_enable_status, gateOut, lowPowerMode, baseTick, primaryTick;
    logic sequencerTick, adcTrigger, adcSampleHold, converterPriority, currentSampleValid;
    logic prevTick, prevNrst;
    logic [11:0] currentOffset, currentSample;
    logic [15:0] ilCount, vCount, badPhase, lastGap;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////////
    pfcss_top #(.SEQ_CYCLES(SEQ)) DUT (
        .clock(clock), .nrst(nrst), .paramValid(paramValid), .loop_mode_select(mode),
        .calibration_length_exponent(calExp), .currentSample(currentSample),
        .currentSampleValid(currentSampleValid), .offsetMin(12'h064), .offsetMax(offsetMax),
        .enableCmd(enableCmd), .startCmd(startCmd), .faultPin(faultPin), .ocpPin(ocpPin),
        .standbyDelay(16'h0020), .pwmPeriod(16'h00C8), .base_rate_setting(baseHalf),
        .primary_rate_setting(8'h04), .dutyIn(dutyIn), .dutyLoad(dutyLoad),
        .sample_trigger_delay(16'h0004), .sequencer_state_code(sequencer_state_code),
        .switching_enable_status(switching_enable_status), .currentOffset(currentOffset),
        .gateOut(gateOut), .lowPowerMode(lowPowerMode), .baseTick(baseTick),
        .primaryTick(primaryTick), .sequencerTick(sequencerTick), .adcTrigger(adcTrigger),
        .adcChannel(adcChannel), .adcSampleHold(adcSampleHold),
        .converterPriority(converterPriority));

    pfcss_power_stage STAGE (
        .clock(clock), .nrst(nrst), .clearCounts(clearCounts), .gateOut(gateOut),
        .adcTrigger(adcTrigger), .adcChannel(adcChannel), .level(level),
        .currentSample(currentSample), .currentSampleValid(currentSampleValid),
        .ilCount(ilCount), .vCount(vCount), .badPhase(badPhase), .lastGap(lastGap));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clock = ~clock;
    end

    task automatic final_report();
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // State may only move right after a sequencer tick; also the hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles > 40000) begin
            fail_count++;
            final_report();
        end else begin
            if (nrst && prevNrst && sequencer_state_code !== prevState)
                `CHK(prevTick, 1'b1)
            prevState <= sequencer_state_code;
            prevTick <= sequencerTick;
            prevNrst <= nrst;
        end
    end

    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic waitState(pfcss_state_t s, int lim);
        int n;
        n = 0;
        while (sequencer_state_code !== s && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic gateHigh(int w, output int h);
        h = 0;
        repeat (w) begin
            step(1);
            if (gateOut === 1'b1) h++;
        end
    endtask

    task automatic runUp(logic [1:0] m, logic [3:0] e, logic b, logic [11:0] mx);
        int n;
        int lo;
        nrst = 1'b0;
        paramValid = 1'b0;
        enableCmd = 1'b0;
        mode = m;
        calExp = e;
        baseHalf = b;
        offsetMax = mx;
        step(10);
        nrst = 1'b1;
        step(3 * SEQ);
        `CHK(sequencer_state_code, idle_config_state)
        paramValid = 1'b1;
        waitState(offset_calibration_state, 2 * SEQ + 2);
        `CHK(sequencer_state_code, offset_calibration_state)
        n = 0;
        while (sequencer_state_code === offset_calibration_state && n < 4000) begin
            step(1);
            n++;
        end
        lo = ((1 << e) - 1) * PER;
        `CHK(n >= lo && n <= lo + 2 * PER + SEQ, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic modesTest();
        pfcss_state_t want [4] = '{ext_duty_run_state, ext_current_run_state,
            ext_multiplier_run_state, closed_loop_run_state};
        for (int m = 0; m < 4; m++) begin
            runUp(2'(m), (m % 2 == 1) ? 4'h3 : 4'h2, 1'b0, 12'h0C8);
            `CHK(sequencer_state_code, want[m])
            `CHK(currentOffset, level)
            if (m != 3) begin
                step(36 * SEQ);
                `CHK(sequencer_state_code, want[m])
            end
        end
    endtask

    task automatic holdTest();
        int h;
        enableCmd = 1'b1;
        dutyLoad = 1'b1;
        step(1);
        dutyLoad = 1'b0;
        step(2 * PER);
        gateHigh(PER, h);
        `CHK(h, DUTY)
        `CHK(switching_enable_status, 1'b1)
        faultPin = 1'b1;
        step(4);
        gateHigh(PER, h);
        `CHK(h, 0)
        `CHK(switching_enable_status, 1'b0)
        faultPin = 1'b0;
        ocpPin = 1'b1;
        step(4);
        gateHigh(PER, h);
        `CHK(h < DUTY / 4, 1'b1)
        ocpPin = 1'b0;
        step(PER + 4);
        gateHigh(PER, h);
        `CHK(h, DUTY)
        enableCmd = 1'b0;
        step(4);
        gateHigh(PER, h);
        `CHK(h, 0)
        `CHK(sequencer_state_code, closed_loop_run_state)
    endtask

    task automatic standbyTest();
        `CHK(lowPowerMode, 1'b0)
        step(20 * SEQ);
        `CHK(sequencer_state_code, closed_loop_run_state)
        waitState(low_power_state, 20 * SEQ);
        `CHK(sequencer_state_code, low_power_state)
        // Flag lags the state by a cycle
        step(1);
        `CHK(lowPowerMode, 1'b1)
        startCmd = 1'b1;
        waitState(idle_config_state, 4 * SEQ);
        `CHK(sequencer_state_code, idle_config_state)
        startCmd = 1'b0;
        waitState(offset_calibration_state, 4 * SEQ);
        `CHK(sequencer_state_code, offset_calibration_state)
    endtask

    task automatic failTest();
        runUp(2'h3, 4'h2, 1'b0, 12'h080);
        `CHK(sequencer_state_code, fault_lock_state)
        startCmd = 1'b1;
        enableCmd = 1'b1;
        faultPin = 1'b1;
        step(6 * SEQ);
        startCmd = 1'b0;
        faultPin = 1'b0;
        step(6 * SEQ);
        `CHK(sequencer_state_code, fault_lock_state)
    endtask

    task automatic rateTest(logic b);
        int nb, np, ns, nh;
        runUp(2'h3, 4'h2, b, 12'h0C8);
        enableCmd = 1'b1;
        dutyLoad = 1'b1;
        step(1);
        dutyLoad = 1'b0;
        step(2 * PER);
        clearCounts = 1'b1;
        step(1);
        clearCounts = 1'b0;
        nb = 0;
        np = 0;
        ns = 0;
        nh = 0;
        repeat (8 * PER) begin
            step(1);
            if (baseTick === 1'b1) nb++;
            if (primaryTick === 1'b1) np++;
            if (sequencerTick === 1'b1) ns++;
            if (adcSampleHold === 1'b1) nh++;
        end
        `CHK(nb, b ? 4 : 8)
        `CHK(np, b ? 1 : 2)
        `CHK(ns, 8 * PER / SEQ)
        `CHK(ilCount, b ? 16'h0004 : 16'h0008)
        `CHK(vCount, 16'h0018)
        `CHK(badPhase, 16'h0000)
        `CHK(lastGap, 16'h001D)
        `CHK(nh, (b ? 28 : 32) * 9)
        `CHK(converterPriority, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        step(10);
        nrst = 1'b1;
        modesTest();
        holdTest();
        standbyTest();
        failTest();
        rateTest(1'b0);
        rateTest(1'b1);
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
